// File: oms_host_model.sv
/*
 host side model: drives reset and the three mode pins.
 assumes the bench calls boot from its main sequence.
*/
`timescale 1ns/1ps
module oms_host_model (
  input wire logic clk_sys,
  output logic rst_b,
  output logic mode_pin0,
  output logic mode_pin1,
  output logic mode_pin2
);
  initial begin
    rst_b = 1'b0;
    {mode_pin2, mode_pin1, mode_pin0} = 3'h0;
  end
  // reset low 4 cycles with pins set, pins flipped 5 cycles after release
  task automatic boot(input logic [2:0] m);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    {mode_pin2, mode_pin1, mode_pin0} <= m;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk_sys);
    {mode_pin2, mode_pin1, mode_pin0} <= ~m;
    repeat (4) @(posedge clk_sys);
  endtask : boot
endmodule : oms_host_model

// File: oms_mode_select.sv
/*
 operating mode select: latches the mode at reset release and derives
 the bus kind, strobe roles, port 3/4 use, address decode and interrupt
 vector selection. assumes one e-rate clock and synchronous pins.
*/
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
module oms_mode_select
  import oms_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic mode_pin0,
  input wire logic mode_pin1,
  input wire logic mode_pin2,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire oms_pkg::oms_cpu_acc_t cpu_acc,
  input wire logic insn_done,
  input wire oms_pkg::oms_irq_in_t irq_in,
  input wire logic [7:0] p4_addr_ddr_sel,
  output logic [2:0] mode,
  output logic mode_bit0,
  output logic mode_bit1,
  output logic mode_bit2,
  output oms_pkg::oms_bus_t bus_kind,
  output oms_pkg::oms_stb_t stb_role,
  output logic rom_enable,
  output logic ram_hit,
  output logic reg_area_hit,
  output logic ext_select_strobe,
  output logic buses_joined,
  output logic [7:0] p4_addr_oe,
  output logic p3_data_bus,
  output logic p3_muxed,
  output logic irq_take,
  output logic [15:0] vec_addr
);
  import oms_pkg::*;

  logic rst_s1_q, rst_s2_q;
  logic armed_q;
  logic [2:0] mode_q, mode_d;
  logic [7:0] p4_ddr_q;
  logic [7:0] rdata_q;
  logic take_q;
  logic [15:0] vec_q;
  logic sel_q, ram_q, regh_q, rom_q, join_q;
  logic [7:0] p4oe_q;
  logic p3d_q, p3m_q;
  oms_bus_t bus_q;
  oms_stb_t stb_q;

  function automatic oms_bus_t kind_of(input logic [2:0] m);
    if (m == MODE_SINGLE_TEST || m == MODE_SINGLE)
      kind_of = OMS_SINGLE;
    else if (m == MODE_NMUX)
      kind_of = OMS_NMUX;
    else
      kind_of = OMS_MUX;
  endfunction : kind_of

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_n = rst_s2_q;

  // mode latch and one-way switch
  wire wr_p2 = reg_wr && reg_addr == REG_P2_DATA;
  wire sw_45 = wr_p2 && reg_wdata[P2_SWITCH_BIT]
    && mode_q == MODE_SINGLE_TEST;
  always_comb begin
    mode_d = mode_q;
    if (!armed_q)
      mode_d = {mode_pin2, mode_pin1, mode_pin0};
    else if (sw_45)
      mode_d = MODE_NMUX;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
      mode_q <= MODE_MUX_TEST;
    end else begin
      armed_q <= 1'b1;
      mode_q <= mode_d;
    end
  end

  wire oms_bus_t kind = kind_of(mode_q);
  wire [7:0] alo = cpu_acc.addr[7:0];
  wire [15:0] a = cpu_acc.addr;

  // port 4 direction, written by software
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      p4_ddr_q <= 8'h00;
    else if (reg_wr && reg_addr == REG_P4_DDR)
      p4_ddr_q <= reg_wdata;
  end

  // decode
  wire is_reg = cpu_acc.valid && a[15:8] == 8'h00
    && alo < REG_AREA_SIZE;
  wire is_ram_t = cpu_acc.valid && alo >= RAM_LO;
  wire is_sel = cpu_acc.valid && kind == OMS_NMUX
    && a >= NMUX_EXT_LO && a <= NMUX_EXT_HI;
  wire rom_on = mode_q != MODE_SINGLE_TEST;
  wire [7:0] p4oe_d = (kind == OMS_SINGLE) ? 8'h00 :
    (mode_q == MODE_MUX_PART || kind == OMS_NMUX) ? p4_ddr_q :
    8'hff;
  wire oms_stb_t stb_d = (kind == OMS_SINGLE) ? STB_IN3_OUT3 :
    (kind == OMS_NMUX) ? STB_SEL_RW : STB_AS_RW;

  // interrupt arbitration
  wire [3:0] int_req = irq_in.irq_int & irq_in.int_en;
  wire ext_ok = irq_in.irq_ext && !irq_in.mask_i;
  wire int_ok = |int_req && !irq_in.mask_i;
  wire [3:0] vsel = irq_in.nmi ? VEC_NMI :
    ext_ok ? VEC_EXT :
    int_req[3] ? VEC_ICF :
    int_req[2] ? VEC_OCF :
    int_req[1] ? VEC_TOF : VEC_SCI;
  wire [15:0] vbase = (mode_q == MODE_MUX_TEST) ? VEC_BASE_EXT :
    VEC_BASE_NORM;
  wire want = irq_in.nmi || ext_ok || int_ok;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      take_q <= 1'b0;
      vec_q <= VEC_BASE_NORM;
    end else begin
      take_q <= want && insn_done;
      if (!armed_q)
        vec_q <= VEC_BASE_NORM;
      else if (want && insn_done)
        vec_q <= vbase | {12'h000, vsel};
      else
        vec_q <= vbase | {12'h000, VEC_RESET};
    end
  end

  // registered outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= 1'b0;
      ram_q <= 1'b0;
      regh_q <= 1'b0;
      rom_q <= 1'b0;
      join_q <= 1'b0;
      p4oe_q <= 8'h00;
      p3d_q <= 1'b0;
      p3m_q <= 1'b0;
      bus_q <= OMS_MUX;
      stb_q <= STB_AS_RW;
      rdata_q <= 8'h00;
    end else begin
      sel_q <= is_sel;
      ram_q <= is_ram_t && (mode_q == MODE_SINGLE_TEST || a[15:8] == 8'h00);
      regh_q <= is_reg;
      rom_q <= rom_on;
      join_q <= mode_q == MODE_MUX_TEST;
      p4oe_q <= p4oe_d & p4_addr_ddr_sel;
      p3d_q <= kind != OMS_SINGLE;
      p3m_q <= kind == OMS_MUX;
      bus_q <= kind;
      stb_q <= stb_d;
      rdata_q <= (reg_rd && reg_addr == REG_P2_DATA) ?
        {mode_q, 5'h00} : 8'h00;
    end
  end

  assign reg_rdata = rdata_q;
  assign mode = mode_q;
  assign mode_bit0 = mode_q[0];
  assign mode_bit1 = mode_q[1];
  assign mode_bit2 = mode_q[2];
  assign bus_kind = bus_q;
  assign stb_role = stb_q;
  assign rom_enable = rom_q;
  assign ram_hit = ram_q;
  assign reg_area_hit = regh_q;
  assign ext_select_strobe = sel_q;
  assign buses_joined = join_q;
  assign p4_addr_oe = p4oe_q;
  assign p3_data_bus = p3d_q;
  assign p3_muxed = p3m_q;
  assign irq_take = take_q;
  assign vec_addr = vec_q;

  // mode classes from the raw codes, apart from kind_of
  wire chk_single = mode_q == MODE_SINGLE_TEST || mode_q == MODE_SINGLE;
  wire chk_nmux = mode_q == MODE_NMUX;
  wire chk_mux = !mode_q[2] || mode_q == MODE_MUX_PART;
  wire sel_win = cpu_acc.valid && a >= NMUX_EXT_LO && a <= NMUX_EXT_HI;

  // mode latch checks
  a_mode_stable: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    armed_q && !sw_45 |=> $stable(mode_q))
    else $error("mode changed without reset");
  a_switch_45: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    armed_q && sw_45 |=> mode_q == MODE_NMUX)
    else $error("mode 4 to 5 switch missed");
  a_no_back_4: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    armed_q && mode_q != MODE_SINGLE_TEST |=> mode_q != MODE_SINGLE_TEST)
    else $error("returned to mode 4");
  a_rdata_mode: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    reg_rd && reg_addr == REG_P2_DATA |=> reg_rdata[7:5] == $past(mode_q))
    else $error("mode readback wrong");
  a_rdata_idle: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without a read");

  // bus kind and strobe roles
  a_bus_single: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    armed_q && chk_single |=> bus_kind == OMS_SINGLE)
    else $error("single chip kind wrong");
  a_bus_nmux: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    armed_q && chk_nmux |=> bus_kind == OMS_NMUX)
    else $error("non-multiplexed kind wrong");
  a_bus_mux: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    armed_q && chk_mux |=> bus_kind == OMS_MUX)
    else $error("multiplexed kind wrong");
  a_stb_single: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    chk_single |=> stb_role == STB_IN3_OUT3)
    else $error("single chip strobes wrong");
  a_stb_nmux: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    chk_nmux |=> stb_role == STB_SEL_RW)
    else $error("non-multiplexed strobes wrong");
  a_stb_mux: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    chk_mux |=> stb_role == STB_AS_RW)
    else $error("multiplexed strobes wrong");

  // memory map
  a_rom_test: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    mode_q == MODE_SINGLE_TEST |=> !rom_enable)
    else $error("rom present in mode 4");
  a_rom_single: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    mode_q == MODE_SINGLE |=> rom_enable)
    else $error("rom missing in single chip");
  a_join_mode0: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    mode_q == MODE_MUX_TEST |=> buses_joined)
    else $error("buses not joined in mode 0");
  a_reg_area: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    cpu_acc.valid && a < {8'h00, REG_AREA_SIZE} |=> reg_area_hit)
    else $error("register area missed");
  a_ram_test: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    chk_single && !mode_q[0] && cpu_acc.valid && alo >= RAM_LO |=> ram_hit)
    else $error("mode 4 ram missed");
  a_sel_range: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ext_select_strobe |-> $past(sel_win) && $past(chk_nmux))
    else $error("select outside range");
  a_sel_hit: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    sel_win && chk_nmux |=> ext_select_strobe)
    else $error("select missed in range");

  // ports 3 and 4
  a_p3_mux: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    chk_mux |=> p3_muxed && p3_data_bus)
    else $error("port 3 not multiplexed");
  a_p3_nmux: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    chk_nmux |=> p3_data_bus && !p3_muxed)
    else $error("port 3 not a data bus");
  a_p3_single: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    chk_single |=> !p3_data_bus && !p3_muxed)
    else $error("port 3 is a bus in single chip");
  a_p4_single: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    chk_single |=> p4_addr_oe == 8'h00)
    else $error("port 4 drives address in single chip");
  a_p4_full: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    chk_mux && mode_q != MODE_MUX_PART |=>
      p4_addr_oe == $past(p4_addr_ddr_sel))
    else $error("port 4 upper address not driven");
  a_p4_ddr_only: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    mode_q == MODE_MUX_PART || chk_nmux |=>
      (p4_addr_oe & ~$past(p4_ddr_q)) == 8'h00)
    else $error("port 4 drives a line set as input");

  // interrupts and vectors
  a_nmi_first: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    irq_in.nmi && insn_done && armed_q |=>
      irq_take && vec_addr[3:0] == VEC_NMI)
    else $error("nmi not taken");
  a_nmi_masked: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    irq_in.nmi && irq_in.mask_i && insn_done |=> irq_take)
    else $error("nmi blocked by mask");
  a_take_done: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !insn_done |=> !irq_take)
    else $error("taken inside an instruction");
  a_ext_over_int: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    armed_q && !irq_in.nmi && ext_ok && |int_req && insn_done
      |=> vec_addr[3:0] == VEC_EXT)
    else $error("internal served before external");
  a_ext_taken: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    armed_q && !irq_in.nmi && irq_in.irq_ext && !irq_in.mask_i
      && insn_done |=> irq_take && vec_addr[3:0] == VEC_EXT)
    else $error("unmasked external request lost");
  a_mask_gate: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !irq_in.nmi && irq_in.mask_i |=> !irq_take)
    else $error("masked request taken");
  a_enable_gate: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !irq_in.nmi && !irq_in.irq_ext
      && (irq_in.irq_int & irq_in.int_en) == 4'h0 |=> !irq_take)
    else $error("disabled request taken");
  a_prio_icf: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    armed_q && !irq_in.nmi && !irq_in.irq_ext && !irq_in.mask_i
      && int_req[3] && insn_done |=> vec_addr[3:0] == VEC_ICF)
    else $error("capture vector wrong");
  a_prio_ocf: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    armed_q && !irq_in.nmi && !irq_in.irq_ext && !irq_in.mask_i
      && int_req[3:2] == 2'h1 && insn_done |=> vec_addr[3:0] == VEC_OCF)
    else $error("compare vector wrong");
  a_prio_sci: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    armed_q && !irq_in.nmi && !irq_in.irq_ext && !irq_in.mask_i
      && int_req == 4'h1 && insn_done |=> vec_addr[3:0] == VEC_SCI)
    else $error("serial vector wrong");
  a_vec_mode0: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    armed_q && mode_q == MODE_MUX_TEST |=>
      vec_addr[15:4] == VEC_BASE_EXT[15:4])
    else $error("mode 0 vectors not relocated");
  a_vec_norm: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    armed_q && mode_q != MODE_MUX_TEST |=>
      vec_addr[15:4] == VEC_BASE_NORM[15:4])
    else $error("vectors not at top of memory");
  a_idle_vec: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    armed_q && !insn_done |=> vec_addr[3:0] == VEC_RESET)
    else $error("idle vector not reset vector");

  c_switch: cover property (@(posedge clk_sys) disable iff (!rst_n) sw_45);
  c_nmux_sel: cover property (@(posedge clk_sys) disable iff (!rst_n)
    ext_select_strobe);
  c_int_take: cover property (@(posedge clk_sys) disable iff (!rst_n)
    irq_take && vec_addr[3:0] == VEC_SCI);
  c_vec_ext: cover property (@(posedge clk_sys) disable iff (!rst_n)
    irq_take && vec_addr[15:4] == VEC_BASE_EXT[15:4]);
  c_p4_part: cover property (@(posedge clk_sys) disable iff (!rst_n)
    p4_addr_oe != 8'h00 && p4_addr_oe != 8'hff);
endmodule : oms_mode_select

// File: oms_mode_select_tb.sv
/*
 self-checking bench for the mode select block.
 assumes oms_pkg and oms_host_model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  $display("[FAIL] %s exp %h got %h", n, e, g); err_total++; end end
module oms_mode_select_tb;
  import oms_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b, mode_pin0, mode_pin1, mode_pin2, mb0, mb1, mb2;
  logic reg_wr = 1'b0, reg_rd = 1'b0, insn_done = 1'b0;
  logic [7:0] reg_addr = 8'h0, reg_wdata = 8'h0, reg_rdata, p4_oe, rd_val;
  oms_cpu_acc_t cpu_acc = '0;
  oms_irq_in_t irq_in = '0;
  logic [2:0] mode;
  logic rom_en, ram_hit, reg_hit, ext_sel, joined, p3_bus, p3_mux, irq_take;
  logic [15:0] vec_addr, base;
  logic [15:0] at [6] = '{16'h001f, 16'h0020, 16'h00ff, 16'h0100,
    16'h01ff, 16'h0200};
  oms_bus_t bus_kind, exp_bus;
  oms_stb_t stb_role, exp_stb;
  int err_total = 0;
  int samples_checked = 0;
  always #5 clk_sys = ~clk_sys;
  oms_host_model host (.clk_sys(clk_sys), .rst_b(rst_b),
    .mode_pin0(mode_pin0), .mode_pin1(mode_pin1), .mode_pin2(mode_pin2));
  oms_mode_select uut (.clk_sys(clk_sys), .rst_b(rst_b),
    .mode_pin0(mode_pin0), .mode_pin1(mode_pin1), .mode_pin2(mode_pin2),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cpu_acc(cpu_acc),
    .insn_done(insn_done), .irq_in(irq_in), .p4_addr_ddr_sel(8'hff),
    .mode(mode), .mode_bit0(mb0), .mode_bit1(mb1), .mode_bit2(mb2),
    .bus_kind(bus_kind), .stb_role(stb_role), .rom_enable(rom_en),
    .ram_hit(ram_hit), .reg_area_hit(reg_hit), .ext_select_strobe(ext_sel),
    .buses_joined(joined), .p4_addr_oe(p4_oe), .p3_data_bus(p3_bus),
    .p3_muxed(p3_mux), .irq_take(irq_take), .vec_addr(vec_addr));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd
  task automatic acc(input logic [15:0] a);
    @(posedge clk_sys);
    cpu_acc <= '{a, 1'b1, 1'b1};
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : acc
  task automatic irq(input oms_irq_in_t v, input logic [15:0] ev);
    logic [15:0] got;
    got = 16'h0;
    @(posedge clk_sys);
    irq_in <= v;
    insn_done <= 1'b1;
    @(posedge clk_sys);
    insn_done <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      #1;
      if (irq_take === 1'b1) got = vec_addr;
      @(posedge clk_sys);
    end
    irq_in <= '0;
    `CHK("vector", ev, got)
  endtask : irq
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #500000;
    err_total++;
    wrap_up;
  end
  initial begin
    for (int m = 0; m < 8; m++) begin
      host.boot(3'(m));
      exp_bus = (m == 4 || m == 7) ? OMS_SINGLE : (m == 5) ? OMS_NMUX : OMS_MUX;
      exp_stb = (m == 4 || m == 7) ? STB_IN3_OUT3 :
        (m == 5) ? STB_SEL_RW : STB_AS_RW;
      base = (m == 0) ? VEC_BASE_EXT : VEC_BASE_NORM;
      `CHK("mode", 3'(m), mode)
      `CHK("mode bits", 3'(m), {mb2, mb1, mb0})
      `CHK("bus", exp_bus, bus_kind)
      `CHK("strobes", exp_stb, stb_role)
      `CHK("rom", 1'(8'hef >> m), rom_en)
      `CHK("joined", m == 0, joined)
      `CHK("p4 oe", m < 4 ? 8'hff : 8'h00, p4_oe)
      `CHK("p3 mux", exp_bus == OMS_MUX, p3_mux)
      `CHK("p3 bus", exp_bus != OMS_SINGLE, p3_bus)
      `CHK("idle vec", base | VEC_RESET, vec_addr)
      rd(REG_P2_DATA);
      `CHK("p2 data", 3'(m), rd_val[7:5])
      irq('{1'b1, 1'b0, 4'h0, 1'b1, 4'h0}, base | VEC_NMI);
      case (m)
        0: begin
          rd(8'h7f);
          `CHK("unmapped", 8'h00, rd_val)
        end
        4: begin
          acc(16'h3480);
          `CHK("ram", 1'b1, ram_hit)
          acc(16'h347f);
          `CHK("ram", 1'b0, ram_hit)
          wr(REG_P2_DATA, 8'h20);
          `CHK("switch", MODE_NMUX, mode)
          `CHK("switch bus", OMS_NMUX, bus_kind)
          wr(REG_P2_DATA, 8'h00);
          `CHK("no return", MODE_NMUX, mode)
        end
        5: begin
          for (int i = 0; i < 6; i++) begin
            acc(at[i]);
            `CHK("ext sel", 1'(6'h18 >> i), ext_sel)
            `CHK("reg area", i == 0, reg_hit)
          end
          wr(REG_P4_DDR, 8'ha5);
          `CHK("p4 ddr", 8'ha5, p4_oe)
        end
        6: begin
          wr(REG_P4_DDR, 8'h0f);
          `CHK("p4 ddr", 8'h0f, p4_oe)
        end
        7: begin
          wr(REG_P2_DATA, 8'h20);
          `CHK("kept", MODE_SINGLE, mode)
          irq('{1'b1, 1'b1, 4'h0, 1'b0, 4'h0}, 16'hfffc);
          irq('{1'b0, 1'b1, 4'h8, 1'b0, 4'h8}, 16'hfff8);
          irq('{1'b0, 1'b0, 4'h9, 1'b0, 4'h9}, 16'hfff6);
          irq('{1'b0, 1'b0, 4'h9, 1'b0, 4'h1}, 16'hfff0);
          irq('{1'b0, 1'b1, 4'h0, 1'b1, 4'h0}, 16'h0000);
          irq('{1'b0, 1'b0, 4'h2, 1'b0, 4'h0}, 16'h0000);
        end
        default: ;
      endcase
    end
    wrap_up;
  end
endmodule : oms_mode_select_tb

// File: oms_pkg.sv
/*
 mode select package: mode codes, strobe roles, map constants, vectors.
 assumes nothing beyond a systemverilog compiler.
*/
package oms_pkg;
  typedef logic [2:0] oms_mode_t;
  localparam oms_mode_t MODE_MUX_TEST = 3'h0;
  localparam oms_mode_t MODE_SINGLE_TEST = 3'h4;
  localparam oms_mode_t MODE_NMUX = 3'h5;
  localparam oms_mode_t MODE_MUX_PART = 3'h6;
  localparam oms_mode_t MODE_SINGLE = 3'h7;
  typedef enum logic [1:0] {OMS_SINGLE, OMS_NMUX, OMS_MUX} oms_bus_t;
  typedef enum logic [1:0] {STB_IN3_OUT3, STB_SEL_RW, STB_AS_RW} oms_stb_t;
  typedef struct packed {
    logic [15:0] addr;
    logic valid;
    logic rd_wr_n;
  } oms_cpu_acc_t;
  typedef struct packed {
    logic nmi;
    logic irq_ext;
    logic [3:0] irq_int;
    logic mask_i;
    logic [3:0] int_en;
  } oms_irq_in_t;
  localparam logic [7:0] REG_P2_DATA = 8'h03;
  localparam logic [7:0] REG_P4_DDR = 8'h05;
  localparam int P2_SWITCH_BIT = 5;
  localparam int P2_MODE_LSB = 5;
  localparam logic [7:0] REG_AREA_SIZE = 8'h20;
  localparam logic [7:0] RAM_LO = 8'h80;
  localparam logic [15:0] NMUX_EXT_LO = 16'h0100;
  localparam logic [15:0] NMUX_EXT_HI = 16'h01ff;
  localparam int ROM_BYTES = 2048;
  localparam int DPRAM_BYTES = 128;
  localparam int SEMA_COUNT = 6;
  localparam int IO_LINES_MAX = 21;
  localparam logic [15:0] VEC_BASE_NORM = 16'hfff0;
  localparam logic [15:0] VEC_BASE_EXT = 16'hbff0;
  localparam logic [3:0] VEC_RESET = 4'he;
  localparam logic [3:0] VEC_NMI = 4'hc;
  localparam logic [3:0] VEC_EXT = 4'h8;
  localparam logic [3:0] VEC_ICF = 4'h6;
  localparam logic [3:0] VEC_OCF = 4'h4;
  localparam logic [3:0] VEC_TOF = 4'h2;
  localparam logic [3:0] VEC_SCI = 4'h0;
  localparam int RST_LOW_ECYC = 3;
  localparam int MODE_SETUP_ECYC = 2;
endpackage : oms_pkg
